// >>> common/eamp_defs.svh
// constants for the external asynchronous memory port
// assumes a 50 MHz core clock and a core-side request/answer handshake
`ifndef EAMP_DEFS_SVH
`define EAMP_DEFS_SVH
`define EAMP_ADDR_W      24
`define EAMP_DATA_W      32
`define EAMP_BANKS       4
`define EAMP_BANK_MSB    23
`define EAMP_BANK_LSB    22
`define EAMP_FLAGS       4
`define EAMP_SETUP_NS    20
`define EAMP_CLK_NS      20
`define EAMP_SETUP_CYC   ((`EAMP_SETUP_NS + `EAMP_CLK_NS - 1) / `EAMP_CLK_NS)
`define EAMP_ACK_SYNC_CYC 2'h3
`define EAMP_MODE_FLAG   2'h0
`define EAMP_MODE_ALT    2'h1
`define EAMP_MODE_BANK   2'h2
`endif

// >>> common/eamp_pkg.sv
// types shared by the external memory port
// assumes eamp_defs.svh supplies widths
`include "eamp_defs.svh"
package eamp_pkg;
  typedef enum logic [1:0] {
    EAMP_IDLE   = 2'b00,
    EAMP_SETUP  = 2'b01,
    EAMP_STROBE = 2'b10,
    EAMP_DONE   = 2'b11
  } eamp_state_t;

  // one access request from the core
  typedef struct packed {
    logic                      write;
    logic [`EAMP_ADDR_W-1:0]   addr;
    logic [`EAMP_DATA_W-1:0]   wdata;
  } eamp_req_t;

  // pin-side strobes
  typedef struct packed {
    logic                      rd_n;
    logic                      wr_n;
    logic [`EAMP_BANKS-1:0]    bank_select_n;
  } eamp_strobe_t;
endpackage

// >>> rtl/eamp_port.sv
// external asynchronous memory port: address, data, bank selects, strobes, ack wait states
// assumes the core holds req_valid until req_done; pins are resolved in the bench
`timescale 1ns/100ps
`include "eamp_defs.svh"
module eamp_port (
  input  wire logic                     ref_clk,           // 50 MHz core clock
  input  wire logic                     resetn,            // async reset, active low
  input  wire logic                     req_valid,         // core asks for an access
  input  wire eamp_pkg::eamp_req_t      req,               // access kind, address, write data
  output logic                          req_done,          // one-cycle pulse, access finished
  output logic [`EAMP_DATA_W-1:0]       rd_data,           // captured read word
  output logic [`EAMP_ADDR_W-1:0]       addr,              // external address pins
  output logic [`EAMP_DATA_W-1:0]       data_out,          // data pins, output value
  output logic                          data_oe,           // data pins driven while high
  input  wire logic [`EAMP_DATA_W-1:0]  data_in,           // data pins, input value
  output logic [1:0]                    bank_select_n,     // bank selects 0 and 1
  output logic                          rd_n,              // read strobe
  output logic                          wr_n,              // write strobe
  input  wire logic                     ack,               // memory acknowledge pin
  input  wire logic                     parallel_input_port_en, // data pins feed parallel input port
  output logic [`EAMP_DATA_W-1:0]       parallel_input_port, // sampled pins for channel zero
  input  wire logic [1:0]               flag2_mode,        // flag two function select
  input  wire logic [1:0]               flag3_mode,        // flag three function select
  input  wire logic [3:0]               flag_out,          // general flag output values
  input  wire logic [3:0]               flag_dir,          // general flag direction, 1 = out
  input  wire logic                     timer_expired,     // timer event for flag three
  input  wire logic [3:0]               flag_pin_in,       // flag pins, input value
  output logic [3:0]                    flag_pin_out,      // flag pins, output value
  output logic [3:0]                    flag_pin_oe,       // flag pins driven while high
  output logic [3:0]                    flag_pullup_en,    // pull-up for bank-select mode
  output logic [3:0]                    flag_in,           // synchronised flag inputs
  output logic                          ext_interrupt_req, // synchronised interrupt from flag two
  output logic                          timer_expired_out  // timer output shown on flag three
);

  // three-stage synchronisers; first stage feeds only the second
  logic [2:0]              ack_sync, next_ack_sync;
  logic                    ack_q, next_ack_q;
  logic [3:0]              flg_s1, flg_s2, flg_s3, flg_q;
  logic [3:0]              next_flg_q;
  logic [`EAMP_DATA_W-1:0] dat_s1, dat_s2, dat_s3, dat_q;
  logic [`EAMP_DATA_W-1:0] next_dat_q;

  // a level counts once stages two and three agree, so a pin caught mid-swing cannot slip through
  always_comb begin
    next_ack_sync = {ack_sync[1:0], ack};
    next_ack_q    = ack_q;
    if (ack_sync[1] == ack_sync[2])
      next_ack_q = ack_sync[2];
    // per bit: set when both agree high, clear when both agree low, else hold
    next_flg_q = (flg_s2 & flg_s3) | (flg_q & (flg_s2 | flg_s3));
    next_dat_q = (dat_s2 & dat_s3) | (dat_q & (dat_s2 | dat_s3));
  end

  // synchroniser flops only; the filtered values lag the pins by four cycles
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ack_sync <= 3'h0;
      ack_q    <= 1'b0;
      flg_s1   <= 4'h0;
      flg_s2   <= 4'h0;
      flg_s3   <= 4'h0;
      flg_q    <= 4'h0;
      dat_s1   <= 32'h0;
      dat_s2   <= 32'h0;
      dat_s3   <= 32'h0;
      dat_q    <= 32'h0;
    end else begin
      ack_sync <= next_ack_sync;
      ack_q    <= next_ack_q;
      flg_s1   <= flag_pin_in;
      flg_s2   <= flg_s1;
      flg_s3   <= flg_s2;
      flg_q    <= next_flg_q;
      dat_s1   <= data_in;
      dat_s2   <= dat_s1;
      dat_s3   <= dat_s2;
      dat_q    <= next_dat_q;
    end
  end

  // access sequencer
  eamp_pkg::eamp_state_t state, next_state;
  eamp_pkg::eamp_req_t   cur, next_cur;
  eamp_pkg::eamp_strobe_t stb, next_stb;
  logic [`EAMP_DATA_W-1:0] next_rd_data;
  logic [`EAMP_BANKS-1:0]  dec;
  logic                    next_done;
  logic                    next_oe;
  logic [1:0]              ack_wait, next_ack_wait;

  // bank decode from the top address bits
  always_comb begin
    dec = {`EAMP_BANKS{1'b1}};
    dec[req.addr[`EAMP_BANK_MSB:`EAMP_BANK_LSB]] = 1'b0;
  end

  always_comb begin
    next_state   = state;
    next_cur     = cur;
    next_stb     = stb;
    next_rd_data = rd_data;
    next_done    = 1'b0;
    next_oe      = data_oe;
    next_ack_wait = ack_wait;
    case (state)
      eamp_pkg::EAMP_IDLE: begin
        next_stb = '{rd_n: 1'b1, wr_n: 1'b1, bank_select_n: {`EAMP_BANKS{1'b1}}};
        next_oe  = 1'b0;
        if (req_valid) begin
          // address and bank select launch together; condition is not looked at
          next_cur               = req;
          next_stb.bank_select_n = dec;
          next_oe                = req.write;
          next_state             = eamp_pkg::EAMP_SETUP;
        end
      end
      eamp_pkg::EAMP_SETUP: begin
        next_stb.rd_n = cur.write;
        next_stb.wr_n = !cur.write;
        next_ack_wait = `EAMP_ACK_SYNC_CYC;
        next_state    = eamp_pkg::EAMP_STROBE;
      end
      eamp_pkg::EAMP_STROBE: begin
        // wait states while ack is low
        // the synced ack lags the pin, so a low raised on select is only trusted once the count runs out
        if (ack_wait != 2'h0) begin
          next_ack_wait = ack_wait - 2'h1;
        end else if (ack_q) begin
          // finish and release strobes and select
          if (!cur.write)
            next_rd_data = data_in;
          next_stb   = '{rd_n: 1'b1, wr_n: 1'b1, bank_select_n: {`EAMP_BANKS{1'b1}}};
          next_done  = 1'b1;
          next_state = eamp_pkg::EAMP_DONE;
        end
      end
      eamp_pkg::EAMP_DONE: begin
        // one hold cycle keeps write data past the strobe edge
        next_oe    = 1'b0;
        next_state = eamp_pkg::EAMP_IDLE;
      end
      default: next_state = eamp_pkg::EAMP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state    <= eamp_pkg::EAMP_IDLE;
      cur      <= '0;
      stb      <= '{rd_n: 1'b1, wr_n: 1'b1, bank_select_n: {`EAMP_BANKS{1'b1}}};
      rd_data  <= 32'h0;
      req_done <= 1'b0;
      data_oe  <= 1'b0;
      ack_wait <= 2'h0;
    end else begin
      state    <= next_state;
      cur      <= next_cur;
      stb      <= next_stb;
      rd_data  <= next_rd_data;
      req_done <= next_done;
      data_oe  <= next_oe;
      ack_wait <= next_ack_wait;
    end
  end

  // pin-function mux, registered so every output is a flop
  logic [3:0]  next_fpo, next_foe, next_fpu;
  logic [`EAMP_DATA_W-1:0] next_pip;
  logic                    next_irq, next_tmr;
  always_comb begin
    next_fpo = flag_out;
    next_foe = flag_dir;
    next_fpu = 4'h0;
    // flag two as flag, interrupt input, or bank two
    if (flag2_mode == `EAMP_MODE_ALT) begin
      next_foe[2] = 1'b0;
    end else if (flag2_mode == `EAMP_MODE_BANK) begin
      // taken from the next select so the pin flips with the address
      next_fpo[2] = next_stb.bank_select_n[2];
      next_foe[2] = 1'b1;
      next_fpu[2] = 1'b1;
    end
    // flag three as flag, timer output, or bank three
    if (flag3_mode == `EAMP_MODE_ALT) begin
      next_fpo[3] = timer_expired;
      next_foe[3] = 1'b1;
    end else if (flag3_mode == `EAMP_MODE_BANK) begin
      // same edge as the address pins
      next_fpo[3] = next_stb.bank_select_n[3];
      next_foe[3] = 1'b1;
      next_fpu[3] = 1'b1;
    end
    // parallel input only while the memory port does not drive the data pins; pins shared
    next_pip = (parallel_input_port_en && !data_oe) ? dat_q : parallel_input_port;
    // alternate functions only show while their mode is selected
    next_irq = (flag2_mode == `EAMP_MODE_ALT) && flg_q[2];
    next_tmr = (flag3_mode == `EAMP_MODE_ALT) && timer_expired;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      // flags come up as inputs, data pins undriven in memory mode
      flag_pin_out        <= 4'h0;
      flag_pin_oe         <= 4'h0;
      flag_pullup_en      <= 4'h0;
      parallel_input_port <= 32'h0;
      flag_in             <= 4'h0;
      ext_interrupt_req   <= 1'b0;
      timer_expired_out   <= 1'b0;
    end else begin
      flag_pin_out        <= next_fpo;
      flag_pin_oe         <= next_foe;
      flag_pullup_en      <= next_fpu;
      parallel_input_port <= next_pip;
      flag_in             <= flg_q;
      ext_interrupt_req   <= next_irq;
      timer_expired_out   <= next_tmr;
    end
  end

  // pins mirror the registered access state
  assign addr          = cur.addr;
  assign data_out      = cur.wdata;
  assign bank_select_n = stb.bank_select_n[1:0];
  assign rd_n          = stb.rd_n;
  assign wr_n          = stb.wr_n;

  AST_IDLE_SEL: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state == eamp_pkg::EAMP_IDLE) |-> (stb.bank_select_n == 4'hf))
    else $error("bank select active while idle");
  // no completion while synced ack low
  AST_ACK_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state == eamp_pkg::EAMP_STROBE && (!ack_q || ack_wait != 2'h0)) |=>
    (state == eamp_pkg::EAMP_STROBE && !req_done))
    else $error("access completed while ack low");
  // ack high ends access next cycle
  AST_ACK_DONE: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state == eamp_pkg::EAMP_STROBE && ack_q && ack_wait == 2'h0) |=>
    (req_done && rd_n && wr_n && stb.bank_select_n == 4'hf))
    else $error("access did not finish after ack");
  // select tracks address bank one cycle after launch
  AST_DECODE: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state == eamp_pkg::EAMP_IDLE && req_valid) |=> !stb.bank_select_n[addr[23:22]])
    else $error("bank select does not match address");
  // read strobe follows setup for reads
  AST_RD: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state == eamp_pkg::EAMP_SETUP && !cur.write) |=> (!rd_n && wr_n))
    else $error("read strobe missing");
  // write strobe follows setup for writes
  AST_WR: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state == eamp_pkg::EAMP_SETUP && cur.write) |=> (!wr_n && rd_n && data_oe))
    else $error("write strobe missing");
  // strobe only with one select active
  AST_SEL_STB: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!rd_n || !wr_n) |-> ($countones(~stb.bank_select_n) == 1))
    else $error("strobe without single bank select");
  AST_ADDR: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state == eamp_pkg::EAMP_STROBE && $past(state) == eamp_pkg::EAMP_STROBE) |-> $stable(addr))
    else $error("address moved during access");
  // bank mode drives pull-up and pin
  AST_F2: assert property (@(posedge ref_clk) disable iff (!resetn)
    (flag2_mode == `EAMP_MODE_BANK) |=> (flag_pin_oe[2] && flag_pullup_en[2]))
    else $error("flag two bank mode not driven");
  AST_F3: assert property (@(posedge ref_clk) disable iff (!resetn)
    (flag3_mode == `EAMP_MODE_ALT) |=> (flag_pin_oe[3] && flag_pin_out[3] == $past(timer_expired)))
    else $error("flag three timer mode wrong");
  // strobe stood long enough for a low ack to reach the sequencer
  AST_ACK_SEEN: assert property (@(posedge ref_clk) disable iff (!resetn)
    req_done |-> ($past(state, 4) == eamp_pkg::EAMP_STROBE))
    else $error("access finished before ack could be seen");
  AST_DONE_PULSE: assert property (@(posedge ref_clk) disable iff (!resetn)
    req_done |=> !req_done)
    else $error("done pulse longer than one cycle");
  // address pins carry the requested address from launch
  AST_LAUNCH: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state == eamp_pkg::EAMP_IDLE && req_valid) |=> (addr == $past(req.addr)))
    else $error("address not launched with request");
  // data pins stay undriven while no access runs
  AST_OE_IDLE: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state == eamp_pkg::EAMP_IDLE) |-> !data_oe)
    else $error("data pins driven while idle");
  // flags in flag mode with no direction set stay inputs
  AST_FLAG_IN: assert property (@(posedge ref_clk) disable iff (!resetn)
    (flag_dir == 4'h0 && flag2_mode == `EAMP_MODE_FLAG && flag3_mode == `EAMP_MODE_FLAG) |=> (flag_pin_oe == 4'h0))
    else $error("flag pins driven while inputs");
  // parallel port holds while disabled or while the port drives the pins
  AST_PIP: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!parallel_input_port_en || data_oe) |=> $stable(parallel_input_port))
    else $error("parallel input moved while not sampling");
  // interrupt mode leaves flag two an input
  AST_F2_IN: assert property (@(posedge ref_clk) disable iff (!resetn)
    (flag2_mode == `EAMP_MODE_ALT) |=> (!flag_pin_oe[2] && ext_interrupt_req == $past(flg_q[2])))
    else $error("flag two interrupt mode wrong");
  // bank two pin follows its select in the same cycle
  AST_BANK2: assert property (@(posedge ref_clk) disable iff (!resetn)
    (flag2_mode == `EAMP_MODE_BANK && $past(flag2_mode) == `EAMP_MODE_BANK) |-> (flag_pin_out[2] == stb.bank_select_n[2]))
    else $error("bank two pin lags its select");
  // bank three pin follows its select in the same cycle
  AST_BANK3: assert property (@(posedge ref_clk) disable iff (!resetn)
    (flag3_mode == `EAMP_MODE_BANK && $past(flag3_mode) == `EAMP_MODE_BANK) |-> (flag_pin_out[3] == stb.bank_select_n[3]))
    else $error("bank three pin lags its select");
endmodule

// >>> test/eamp_mem.sv
// far-side memory with programmable wait states
// assumes sel is the resolved active-high select of any bank
`timescale 1ns/100ps
module eamp_mem (
  input  wire logic        clk,   // core clock
  input  wire logic        sel,   // some bank selected
  input  wire logic        rd_n,  // read strobe
  input  wire logic        wr_n,  // write strobe
  input  wire logic [23:0] addr,  // address pins
  input  wire logic [31:0] wdat,  // data pins from port
  input  wire logic [3:0]  waits, // wait cycles to insert
  input  wire logic        xen,   // other source drives data
  input  wire logic [31:0] xval,  // that source's value
  output logic             ack,   // acknowledge pin
  output logic [31:0]      rdat   // data pins toward port
);
  logic [31:0] mem [16];
  logic [3:0]  cnt = 4'h0;
  assign ack = !(sel && cnt < waits);
  // released pins float to their pull-up level, so a late sample reads all ones
  assign rdat = (!rd_n && sel) ? mem[addr[3:0]] : xen ? xval : 32'hffff_ffff;
  // counts selected cycles; the word is taken while the strobe is low
  always @(posedge clk) begin
    cnt <= sel ? cnt + {3'h0, ~&cnt} : 4'h0;
    if (!wr_n && sel) mem[addr[3:0]] <= wdat;
  end
endmodule

// >>> test/tb.sv
// self-checking bench for the external memory port
// assumes the port body carries its own pin assertions
`timescale 1ns/100ps
`include "eamp_defs.svh"
module tb;
  logic                ref_clk, resetn, req_valid, req_done, data_oe, rd_n, wr_n, ack, parallel_input_port_en;
  logic                timer_expired, ext_interrupt_req, timer_expired_out, xen;
  eamp_pkg::eamp_req_t req;
  logic [31:0]         rd_data, data_out, data_in, parallel_input_port, xval;
  logic [23:0]         addr;
  logic [1:0]          bank_select_n, flag2_mode, flag3_mode;
  logic [3:0]          flag_out, flag_dir, flag_pin_in, flag_pin_out, flag_pin_oe, flag_pullup_en;
  logic [3:0]          flag_in, flag_ext, waits, sel4;
  int                  bad_count = 0;
  int                  num_checks = 0;

  // undriven flag pins float high through their pull-ups
  assign sel4 = {flag_pin_oe[3] ? flag_pin_out[3] : 1'b1, flag_pin_oe[2] ? flag_pin_out[2] : 1'b1, bank_select_n};
  assign flag_pin_in = (flag_pin_oe & flag_pin_out) | (~flag_pin_oe & flag_ext);

  eamp_port i_dut (.*);
  eamp_mem i_mem (.clk(ref_clk), .sel(~&sel4), .rd_n, .wr_n, .addr, .wdat(data_out), .waits, .xen, .xval,
                  .ack, .rdat(data_in));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // inputs always move 1 ns after the edge
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic t_reset();
    tick(16);
    chk("rst sel", {28'h0, sel4}, 32'hf);
    chk("rst strobes", {30'h0, rd_n, wr_n}, 32'h3);
    chk("rst drive", {27'h0, data_oe, flag_pin_oe}, 32'h0);
    resetn = 1'b1;
    flag_ext = 4'ha;
    tick(6);
    chk("flag in", {28'h0, flag_in}, 32'ha);
  endtask

  // one access with w wait cycles; a hang ends the run
  task automatic acc(logic wr, logic [23:0] a, logic [31:0] d, logic [3:0] w, logic [31:0] exp_rd);
    int n;
    int low;
    logic [3:0] exp_sel;
    exp_sel = ~(4'h1 << a[23:22]);
    low = 0;
    waits = w;
    req = '{write: wr, addr: a, wdata: d};
    req_valid = 1'b1;
    for (n = 0; n < 60 && req_done !== 1'b1; n++) begin
      tick(1);
      if (sel4 !== 4'hf && req_done !== 1'b1) chk("sel addr", {8'h0, addr}, {8'h0, a});
      if ((wr ? wr_n : rd_n) === 1'b0) begin
        low++;
        chk("sel", {28'h0, sel4}, {28'h0, exp_sel});
        chk("other strobe", {31'h0, wr ? rd_n : wr_n}, 32'h1);
        chk("drive", {31'h0, data_oe}, {31'h0, wr});
        if (wr) chk("wdata", data_out, d);
      end
    end
    if (req_done !== 1'b1) begin
      bad_count++;
      print_verdict();
    end else begin
      req_valid = 1'b0;
      chk("strobed", {31'h0, low > 0}, 32'h1);
      chk("waited", {31'h0, low >= w}, 32'h1);
      chk("end sel", {26'h0, rd_n, wr_n, sel4}, 32'h3f);
      if (!wr) chk("rdata", rd_data, exp_rd);
      tick(1);
    end
  endtask

  task automatic t_parallel_in();
    parallel_input_port_en = 1'b1;
    xen = 1'b1;
    xval = 32'h1234_abcd;
    tick(6);
    chk("parallel in", parallel_input_port, 32'h1234_abcd);
    xen = 1'b0;
    parallel_input_port_en = 1'b0;
  endtask

  task automatic t_flags();
    flag2_mode = `EAMP_MODE_ALT;
    flag3_mode = `EAMP_MODE_ALT;
    flag_ext = 4'h4;
    timer_expired = 1'b1;
    tick(6);
    chk("irq timer", {30'h0, ext_interrupt_req, timer_expired_out}, 32'h3);
    chk("timer pin", {30'h0, flag_pin_oe[3], flag_pin_out[3]}, 32'h3);
    flag2_mode = `EAMP_MODE_FLAG;
    flag3_mode = `EAMP_MODE_FLAG;
    flag_dir = 4'h3;
    flag_out = 4'h2;
    tick(3);
    chk("gen flags", {24'h0, flag_pin_oe, 2'h0, flag_pin_out[1:0]}, 32'h32);
    flag2_mode = `EAMP_MODE_BANK;
    flag3_mode = `EAMP_MODE_BANK;
    tick(2);
    chk("pullup", {30'h0, flag_pullup_en[3:2]}, 32'h3);
    acc(1'b1, 24'h80_0003, 32'h5a5a_0033, 4'h2, 32'h0);
    acc(1'b0, 24'hc0_0003, 32'h0, 4'h0, 32'h5a5a_0033);
  endtask

  initial begin
    {resetn, req_valid, parallel_input_port_en, timer_expired, xen} = '0;
    {flag2_mode, flag3_mode, flag_out, flag_dir, flag_ext, waits} = '0;
    req = '0;
    xval = '0;
    t_reset();
    acc(1'b1, 24'h00_0005, 32'ha5c3_0f1e, 4'h0, 32'h0);
    acc(1'b0, 24'h00_0005, 32'h0, 4'h0, 32'ha5c3_0f1e);
    acc(1'b1, 24'h7f_fffa, 32'h0ff0_55aa, 4'h6, 32'h0);
    acc(1'b0, 24'h7f_fffa, 32'h0, 4'h9, 32'h0ff0_55aa);
    t_parallel_in();
    t_flags();
    print_verdict();
  end
endmodule
